// ---- include/boot_loader_map.svh ----
// offsets, key values and reset values of the boot stream loader
`ifndef BOOT_LOADER_MAP_SVH
`define BOOT_LOADER_MAP_SVH
`define KEY_WORD_WIDE       16'h10AA
`define KEY_BYTE_WIDE       16'h08AA
`define HEADER_WORDS        4'h8
`define HEADER_REGINIT_IDX  4'h0
`define END_LENGTH          16'h0000
`define FLASH_ENTRY_DEFAULT 22'h3F7FF6
`define ENTRY_RESET         22'h000000
`endif

// ---- include/boot_loader_pkg.sv ----
// types of the boot stream loader
package boot_loader_pkg;
    typedef enum logic [1:0] {
        PORT_SERIAL,
        PORT_EEPROM,
        PORT_PARALLEL
    } port_sel_t;
    typedef enum logic [1:0] {
        ACCEPT_BYTE,
        ACCEPT_WORD,
        ACCEPT_BOTH
    } width_set_t;
endpackage

// ---- hdl/byte_pair_joiner.sv ----
// joins byte-wide stream elements into 16-bit words, low byte first
`timescale 1ns/1ps
module byte_pair_joiner (
    input  wire logic        clk_in,
    input  wire logic        nrst_in,
    input  wire logic        clear_in,
    input  wire logic        byte_valid_in,
    input  wire logic [7:0]  byte_in,
    output logic             word_valid_out,
    output logic [15:0]      word_out
);
    logic       have_low_q;
    logic [7:0] low_q;

    // low byte held until high byte arrives
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            have_low_q     <= 1'b0;
            low_q          <= 8'h00;
            word_valid_out <= 1'b0;
            word_out       <= 16'h0000;
        end else begin
            word_valid_out <= 1'b0;
            if (clear_in) begin
                have_low_q <= 1'b0;
            end else if (byte_valid_in) begin
                if (have_low_q) begin
                    word_out       <= {byte_in, low_q};
                    word_valid_out <= 1'b1;
                    have_low_q     <= 1'b0;
                end else begin
                    low_q      <= byte_in;
                    have_low_q <= 1'b1;
                end
            end
        end
    end
endmodule // byte_pair_joiner

// ---- hdl/width_key_check.sv ----
// decides which stream width a key word names and whether the port takes it
`timescale 1ns/1ps
`include "boot_loader_map.svh"
module width_key_check (
    input  wire logic                     clk_in,
    input  wire logic                     nrst_in,
    input  wire logic                     check_in,
    input  wire logic [15:0]              key_in,
    input  wire logic                     first_in,
    input  wire boot_loader_pkg::port_sel_t port_in,
    output logic                          is_word_out,
    output logic                          is_byte_out,
    output logic                          bad_out,
    output logic                          result_out
);
    // width set each port accepts; parallel port takes both
    function automatic boot_loader_pkg::width_set_t port_widths(input boot_loader_pkg::port_sel_t p);
        case (p)
            boot_loader_pkg::PORT_SERIAL:   port_widths = boot_loader_pkg::ACCEPT_BYTE;
            boot_loader_pkg::PORT_EEPROM:   port_widths = boot_loader_pkg::ACCEPT_BYTE;
            boot_loader_pkg::PORT_PARALLEL: port_widths = boot_loader_pkg::ACCEPT_BOTH;
            default:                        port_widths = boot_loader_pkg::ACCEPT_BOTH;
        endcase
    endfunction

    boot_loader_pkg::width_set_t set_w;
    logic                        word_ok;
    logic                        byte_ok;
    assign set_w   = port_widths(port_in);
    assign word_ok = (set_w != boot_loader_pkg::ACCEPT_BYTE);
    assign byte_ok = (set_w != boot_loader_pkg::ACCEPT_WORD);

    // first value compared with word key, joined pair with byte key
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            is_word_out <= 1'b0;
            is_byte_out <= 1'b0;
            bad_out     <= 1'b0;
            result_out  <= 1'b0;
        end else begin
            result_out  <= check_in;
            if (check_in) begin
                is_word_out <= first_in && key_in == `KEY_WORD_WIDE && word_ok;
                is_byte_out <= !first_in && key_in == `KEY_BYTE_WIDE && byte_ok;
                bad_out     <= first_in ? (key_in == `KEY_WORD_WIDE && !word_ok)
                                        : !(key_in == `KEY_BYTE_WIDE && byte_ok);
            end
        end
    end
endmodule // width_key_check

// ---- hdl/boot_stream_block_loader.sv ----
// boot stream parser that writes blocks into memory and hands over the entry
`timescale 1ns/1ps
`include "boot_loader_map.svh"
// Operation
// - the first stream word is a key naming an 8-bit (0x08AA) or 16-bit (0x10AA) stream.
// - a key matching neither value aborts the load and reports the fixed flash entry address.
// - a key naming a width the active port does not accept is treated as invalid.
// - the parallel port accepts both byte-wide and word-wide streams.
// - eight header words follow the key and unused ones are read and discarded.
// - only the EEPROM path takes the first header word as a register initialisation value.
// - words ten and eleven form the 22-bit entry address, upper part first.
// - word twelve is the first block length, counted in 16-bit words for both widths.
// - the two words after a length are the destination address, upper half first.
// - exactly the counted data words are written at consecutive addresses from the destination.
// - length, address and data repeat per block and a zero length ends the transfer.
// - at the zero length the captured entry address is presented for execution.
// - in word-wide format each element is used directly as one 16-bit word.
// - in byte-wide format each word arrives low byte first and is rebuilt in that order.
// - the first value is tried as the word key, and only on mismatch a second is read for the byte key.
module boot_stream_block_loader (
    input  wire logic                       clk_in,
    input  wire logic                       nrst_in,
    input  wire logic                       start_in,
    input  wire boot_loader_pkg::port_sel_t port_in,
    input  wire logic                       elem_valid_in,
    input  wire logic [15:0]                elem_in,
    output logic                            busy_out,
    output logic                            mem_we_out,
    output logic [31:0]                     mem_addr_out,
    output logic [15:0]                     mem_data_out,
    output logic [15:0]                     reg_init_out,
    output logic                            reg_init_valid_out,
    output logic [21:0]                     entry_out,
    output logic                            entry_valid_out,
    output logic                            done_out,
    output logic                            abort_out
);
    typedef enum logic [3:0] {
        ST_IDLE, ST_KEY1, ST_KEY2, ST_WAIT_CHECK, ST_HEADER,
        ST_ENTRY_HI, ST_ENTRY_LO, ST_LENGTH, ST_ADDR_HI, ST_ADDR_LO, ST_DATA
    } load_state_t;

    // =====================================================
    // stream element intake
    // =====================================================
    load_state_t state_q;
    logic        byte_mode_q;
    logic [7:0]  key_low_q;
    logic        word_valid;
    logic [15:0] word_val;
    logic        joined_valid;
    logic [15:0] joined_word;
    logic        clear_join;

    assign clear_join = (state_q == ST_IDLE);

    byte_pair_joiner u_join (
        .clk_in         (clk_in),
        .nrst_in        (nrst_in),
        .clear_in       (clear_join),
        .byte_valid_in  (elem_valid_in && byte_mode_q),
        .byte_in        (elem_in[7:0]),
        .word_valid_out (joined_valid),
        .word_out       (joined_word)
    );

    // word source: direct element or rebuilt byte pair
    assign word_valid = byte_mode_q ? joined_valid : elem_valid_in;
    assign word_val   = byte_mode_q ? joined_word : elem_in;

    // =====================================================
    // key detection
    // =====================================================
    logic        chk_go;
    logic [15:0] chk_key;
    logic        chk_first;
    logic        key_word;
    logic        key_byte;
    logic        key_bad;
    logic        key_ready;

    assign chk_go    = elem_valid_in && (state_q == ST_KEY1 || state_q == ST_KEY2);
    assign chk_first = (state_q == ST_KEY1);
    // second byte value joins with the first as its high byte
    assign chk_key   = chk_first ? elem_in : {elem_in[7:0], key_low_q};

    width_key_check u_key (
        .clk_in      (clk_in),
        .nrst_in     (nrst_in),
        .check_in    (chk_go),
        .key_in      (chk_key),
        .first_in    (chk_first),
        .port_in     (port_in),
        .is_word_out (key_word),
        .is_byte_out (key_byte),
        .bad_out     (key_bad),
        .result_out  (key_ready)
    );

    // =====================================================
    // parse sequencer
    // =====================================================
    logic        key_first_q;
    logic [3:0]  hdr_cnt_q;
    logic [15:0] left_q;
    logic [5:0]  entry_hi_q;

    // state sequence over key, header, entry and blocks
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            state_q <= ST_IDLE;
        end else begin
            case (state_q)
                ST_IDLE:       if (start_in) state_q <= ST_KEY1;
                ST_KEY1:       if (elem_valid_in) state_q <= ST_WAIT_CHECK;
                ST_KEY2:       if (elem_valid_in) state_q <= ST_WAIT_CHECK;
                ST_WAIT_CHECK: begin
                    if (key_ready) begin
                        if (key_word || key_byte) state_q <= ST_HEADER;
                        else if (key_bad) state_q <= ST_IDLE;
                        else state_q <= ST_KEY2;
                    end
                end
                ST_HEADER:     if (word_valid && hdr_cnt_q == `HEADER_WORDS - 4'h1) state_q <= ST_ENTRY_HI;
                ST_ENTRY_HI:   if (word_valid) state_q <= ST_ENTRY_LO;
                ST_ENTRY_LO:   if (word_valid) state_q <= ST_LENGTH;
                ST_LENGTH: begin
                    if (word_valid) state_q <= (word_val == `END_LENGTH) ? ST_IDLE : ST_ADDR_HI;
                end
                ST_ADDR_HI:    if (word_valid) state_q <= ST_ADDR_LO;
                ST_ADDR_LO:    if (word_valid) state_q <= ST_DATA;
                ST_DATA:       if (word_valid && left_q == 16'h0001) state_q <= ST_LENGTH;
                default:       state_q <= ST_IDLE;
            endcase
        end
    end

    // stream width chosen by the accepted key
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            byte_mode_q <= 1'b0;
            key_low_q   <= 8'h00;
            key_first_q <= 1'b0;
        end else begin
            if (state_q == ST_IDLE) byte_mode_q <= 1'b0;
            else if (key_ready && key_byte) byte_mode_q <= 1'b1;
            if (state_q == ST_KEY1 && elem_valid_in) key_low_q <= elem_in[7:0];
            key_first_q <= chk_first;
        end
    end

    // header word counter, discards unused words
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            hdr_cnt_q <= 4'h0;
        end else if (state_q != ST_HEADER) begin
            hdr_cnt_q <= 4'h0;
        end else if (word_valid) begin
            hdr_cnt_q <= hdr_cnt_q + 4'h1;
        end
    end

    // register initialisation word, eeprom path only
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            reg_init_out       <= 16'h0000;
            reg_init_valid_out <= 1'b0;
        end else begin
            reg_init_valid_out <= 1'b0;
            if (state_q == ST_HEADER && word_valid && hdr_cnt_q == `HEADER_REGINIT_IDX
                && port_in == boot_loader_pkg::PORT_EEPROM) begin
                reg_init_out       <= word_val;
                reg_init_valid_out <= 1'b1;
            end
        end
    end

    // block length and destination address tracking
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            left_q       <= 16'h0000;
            mem_addr_out <= 32'h0000_0000;
            mem_data_out <= 16'h0000;
            mem_we_out   <= 1'b0;
        end else begin
            mem_we_out <= 1'b0;
            if (word_valid) begin
                case (state_q)
                    ST_LENGTH:  left_q <= word_val;
                    ST_ADDR_HI: mem_addr_out[31:16] <= word_val;
                    ST_ADDR_LO: mem_addr_out[15:0] <= word_val;
                    ST_DATA: begin
                        mem_data_out <= word_val;
                        mem_we_out   <= 1'b1;
                        left_q       <= left_q - 16'h0001;
                    end
                    default: left_q <= left_q;
                endcase
            end
            // step the address after each written word
            if (mem_we_out) mem_addr_out <= mem_addr_out + 32'h0000_0001;
        end
    end

    // entry address capture and hand-over
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            entry_hi_q      <= 6'h00;
            entry_out       <= `ENTRY_RESET;
            entry_valid_out <= 1'b0;
            done_out        <= 1'b0;
            abort_out       <= 1'b0;
        end else begin
            done_out  <= 1'b0;
            abort_out <= 1'b0;
            if (state_q == ST_IDLE && start_in) entry_valid_out <= 1'b0;
            if (state_q == ST_ENTRY_HI && word_valid) entry_hi_q <= word_val[5:0];
            if (state_q == ST_ENTRY_LO && word_valid) entry_out <= {entry_hi_q, word_val};
            if (state_q == ST_LENGTH && word_valid && word_val == `END_LENGTH) begin
                done_out        <= 1'b1;
                entry_valid_out <= 1'b1;
            end
            if (state_q == ST_WAIT_CHECK && key_ready && key_bad) begin
                entry_out       <= `FLASH_ENTRY_DEFAULT;
                entry_valid_out <= 1'b1;
                abort_out       <= 1'b1;
            end
        end
    end

    // busy while a load is in progress
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) busy_out <= 1'b0;
        else busy_out <= (state_q != ST_IDLE) || start_in;
    end

    // =====================================================
    // checks
    // =====================================================
    // key and width decisions
    byte_key_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
        key_ready && key_byte |-> !key_first_q)
        else $error("byte key on first value");
    word_first_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
        key_ready && key_word |-> key_first_q)
        else $error("word key not on first value");
    serial_word_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
        key_ready && key_word |-> $past(port_in) == boot_loader_pkg::PORT_PARALLEL)
        else $error("word stream on byte-only port");
    byte_mode_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
        state_q == ST_WAIT_CHECK && key_ready && key_byte |=> byte_mode_q && state_q == ST_HEADER)
        else $error("byte key did not start byte stream");
    key_abort_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
        state_q == ST_WAIT_CHECK && key_ready && key_bad |=> abort_out && state_q == ST_IDLE)
        else $error("bad key did not abort");
    abort_flash_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
        abort_out |-> entry_out == `FLASH_ENTRY_DEFAULT)
        else $error("abort entry wrong");
    byte_order_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
        word_valid && byte_mode_q |-> word_val[15:8] == $past(elem_in[7:0]))
        else $error("high byte not taken second");

    // header and entry words
    header_count_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
        state_q == ST_ENTRY_HI && $past(state_q) == ST_HEADER |-> $past(hdr_cnt_q) == `HEADER_WORDS - 4'h1)
        else $error("header word count wrong");
    eeprom_only_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
        reg_init_valid_out |-> $past(port_in) == boot_loader_pkg::PORT_EEPROM)
        else $error("register init on wrong port");
    reg_init_word_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
        reg_init_valid_out |-> $past(state_q) == ST_HEADER && $past(hdr_cnt_q) == `HEADER_REGINIT_IDX)
        else $error("register init from wrong header word");
    entry_low_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
        state_q == ST_ENTRY_LO && word_valid |=> entry_out[15:0] == $past(word_val))
        else $error("entry low half not captured");

    // blocks, writes and end of stream
    length_load_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
        state_q == ST_LENGTH && word_valid && word_val != 16'h0000 |=> left_q == $past(word_val))
        else $error("length not captured");
    addr_high_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
        state_q == ST_ADDR_HI && word_valid |=> mem_addr_out[31:16] == $past(word_val))
        else $error("destination upper half not captured");
    addr_low_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
        state_q == ST_ADDR_LO && word_valid |=> mem_addr_out[15:0] == $past(word_val))
        else $error("destination lower half not captured");
    data_write_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
        state_q == ST_DATA && word_valid |=> mem_we_out && mem_data_out == $past(word_val))
        else $error("data word not written");
    write_step_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
        mem_we_out ##1 mem_we_out |-> mem_addr_out == $past(mem_addr_out) + 32'h1)
        else $error("write address not consecutive");
    data_end_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
        state_q == ST_DATA && word_valid && left_q == 16'h0001 |=> state_q == ST_LENGTH)
        else $error("block did not end after its count");
    zero_end_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
        state_q == ST_LENGTH && word_valid && word_val == 16'h0000 |=> done_out && state_q == ST_IDLE)
        else $error("zero length did not end");
    done_entry_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
        done_out |-> entry_valid_out && !abort_out)
        else $error("done without entry");
    entry_clear_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
        state_q == ST_IDLE && start_in |=> !entry_valid_out)
        else $error("entry still valid after start");
endmodule // boot_stream_block_loader

// ---- sim/stream_source.sv ----
// far-side stream source that feeds boot stream elements to the loader
`timescale 1ns/1ps
module stream_source (
    input  wire logic        clk_in,
    output logic             elem_valid_out,
    output logic [15:0]      elem_out
);
    // ==================================================
    // element queue filled by the bench
    logic [15:0] q[$];

    initial begin
        elem_valid_out = 1'b0;
        elem_out       = 16'h0000;
    end

    // one element at the next edge; gap leaves an idle edge after it,
    // which keys need since the check-wait edge ignores elements
    task automatic put(input logic [15:0] v, input bit gap);
        elem_valid_out = 1'b1;
        elem_out       = v;
        @(posedge clk_in);
        #1;
        if (gap) begin
            elem_valid_out = 1'b0;
            elem_out       = ~v; // released line shows no stale value
            @(posedge clk_in);
            #1;
        end
    endtask

    // sends the whole queue, byte pairs low byte first in byte mode;
    // fast sends every word after the key back to back
    task automatic run(input bit byte_mode, input bit fast);
        logic [15:0] w;
        bit          gap;
        gap = 1'b1;
        w   = 16'h0000;
        while (q.size() > 0) begin
            w = q.pop_front();
            if (byte_mode) begin
                put({8'h00, w[7:0]}, gap);
                put({8'h00, w[15:8]}, gap);
            end else begin
                put(w, gap);
            end
            gap = !fast;
        end
        elem_valid_out = 1'b0;
        elem_out       = ~w;
    endtask
endmodule // stream_source

// ---- sim/tb_boot_stream_block_loader.sv ----
// self-checking bench of the boot stream block loader
`timescale 1ns/1ps
`include "boot_loader_map.svh"
module tb_boot_stream_block_loader;
    // ==================================================
    // signals and counters
    logic                       clk_in;
    logic                       nrst_in;
    logic                       start_in;
    boot_loader_pkg::port_sel_t port_in;
    logic                       elem_valid_in;
    logic [15:0]                elem_in;
    logic                       busy_out;
    logic                       mem_we_out;
    logic [31:0]                mem_addr_out;
    logic [15:0]                mem_data_out;
    logic [15:0]                reg_init_out;
    logic                       reg_init_valid_out;
    logic [21:0]                entry_out;
    logic                       entry_valid_out;
    logic                       done_out;
    logic                       abort_out;
    int                         fail_count = 0;
    int                         tests_run = 0;
    int                         cycles = 0;
    int                         n_done = 0;
    int                         n_abort = 0;
    int                         n_init = 0;
    logic [15:0]                last_init = 16'h0000;
    logic [47:0]                got[$];
    logic [47:0]                exp_w[$];

    boot_stream_block_loader dut_u (
        .clk_in(clk_in), .nrst_in(nrst_in), .start_in(start_in), .port_in(port_in),
        .elem_valid_in(elem_valid_in), .elem_in(elem_in), .busy_out(busy_out),
        .mem_we_out(mem_we_out), .mem_addr_out(mem_addr_out), .mem_data_out(mem_data_out),
        .reg_init_out(reg_init_out), .reg_init_valid_out(reg_init_valid_out),
        .entry_out(entry_out), .entry_valid_out(entry_valid_out),
        .done_out(done_out), .abort_out(abort_out)
    );

    stream_source src_u (
        .clk_in(clk_in), .elem_valid_out(elem_valid_in), .elem_out(elem_in)
    );

    // ==================================================
    // clock, output monitor and hang guard
    initial begin
        clk_in = 1'b0;
        forever #2 clk_in = ~clk_in;
    end

    always @(posedge clk_in) begin
        cycles++;
        if (mem_we_out === 1'b1) got.push_back({mem_addr_out, mem_data_out});
        if (done_out === 1'b1) n_done++;
        if (abort_out === 1'b1) n_abort++;
        if (reg_init_valid_out === 1'b1) begin
            n_init++;
            last_init = reg_init_out;
        end
        if (cycles == 5000) begin
            fail_count++;
            $display("ERROR %0t run too long", $time);
            stop_test();
        end
    end

    // ==================================================
    // shared tasks
    task automatic check(input bit ok, input string msg);
        tests_run++;
        if (!ok) begin
            fail_count++;
            $display("ERROR %0t %s", $time, msg);
        end
    endtask

    task automatic stop_test();
        $display("counts: %0d checks, %0d mismatches", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    // key, eight header words with the first one set, entry words
    task automatic push_hdr(input logic [15:0] key, init, ehi, elo);
        src_u.q.push_back(key);
        src_u.q.push_back(init);
        repeat (7) src_u.q.push_back(16'h0000);
        src_u.q.push_back(ehi);
        src_u.q.push_back(elo);
    endtask

    // one block and its expected writes at consecutive addresses
    task automatic push_blk(input logic [15:0] len, ahi, alo, d0);
        src_u.q.push_back(len);
        src_u.q.push_back(ahi);
        src_u.q.push_back(alo);
        for (int i = 0; i < len; i++) begin
            src_u.q.push_back(d0 + 16'(i));
            exp_w.push_back({{ahi, alo} + 32'(i), d0 + 16'(i)});
        end
    endtask

    // starts a load, sends the stream and waits for its end
    task automatic run_load(input boot_loader_pkg::port_sel_t p, input bit byte_mode, input bit fast);
        n_done = 0;
        n_abort = 0;
        n_init = 0;
        got.delete();
        @(posedge clk_in);
        #1 port_in = p;
        start_in = 1'b1;
        @(posedge clk_in);
        #1 start_in = 1'b0;
        src_u.run(byte_mode, fast);
        for (int i = 0; i < 20 && n_done + n_abort == 0; i++) @(posedge clk_in);
        repeat (2) @(posedge clk_in);
        #1;
    endtask

    // judges a normal end: writes, done pulse and entry
    task automatic end_ok(input logic [21:0] entry, input int inits);
        check(n_done == 1 && n_abort == 0, "no single done pulse");
        check(entry_out === entry && entry_valid_out === 1'b1, "entry wrong");
        check(n_init == inits, "register init count wrong");
        check(busy_out === 1'b0, "still busy after end");
        check(got.size() == exp_w.size(), "write count wrong");
        for (int i = 0; i < got.size() && i < exp_w.size(); i++)
            check(got[i] === exp_w[i], "write address or data wrong");
        exp_w.delete();
    endtask

    // ==================================================
    // scenarios
    task automatic t_word_parallel();
        push_hdr(16'h10AA, 16'hBEEF, 16'h003F, 16'h8000);
        push_blk(16'h0005, 16'h003F, 16'h9010, 16'h0001);
        push_blk(16'h0002, 16'h0001, 16'hFFFF, 16'hA55A);
        src_u.q.push_back(`END_LENGTH);
        run_load(boot_loader_pkg::PORT_PARALLEL, 1'b0, 1'b1);
        end_ok(22'h3F8000, 0);
        $display("test word stream on parallel port finished");
    endtask

    task automatic t_byte_parallel();
        push_hdr(16'h08AA, 16'h0000, 16'h0015, 16'h1234);
        push_blk(16'h0003, 16'h0000, 16'h0400, 16'h7700);
        src_u.q.push_back(`END_LENGTH);
        run_load(boot_loader_pkg::PORT_PARALLEL, 1'b1, 1'b1);
        end_ok(22'h151234, 0);
        $display("test byte stream on parallel port finished");
    endtask

    task automatic t_byte_eeprom_empty();
        push_hdr(16'h08AA, 16'h1234, 16'h0001, 16'h0002);
        src_u.q.push_back(`END_LENGTH);
        run_load(boot_loader_pkg::PORT_EEPROM, 1'b1, 1'b0);
        end_ok(22'h010002, 1);
        check(last_init === 16'h1234, "register init value wrong");
        $display("test empty byte stream on eeprom port finished");
    endtask

    task automatic t_byte_serial();
        push_hdr(16'h08AA, 16'h5A5A, 16'h0020, 16'h0100);
        push_blk(16'h0001, 16'h0000, 16'h0010, 16'hC3C3);
        src_u.q.push_back(`END_LENGTH);
        run_load(boot_loader_pkg::PORT_SERIAL, 1'b1, 1'b0);
        end_ok(22'h200100, 0);
        $display("test byte stream on serial port finished");
    endtask

    task automatic t_reject();
        boot_loader_pkg::port_sel_t ports[3] = '{boot_loader_pkg::PORT_SERIAL,
            boot_loader_pkg::PORT_EEPROM, boot_loader_pkg::PORT_PARALLEL};
        logic [15:0] keys[3] = '{16'h10AA, 16'h10AA, 16'h1234};
        for (int i = 0; i < 3; i++) begin
            src_u.q.push_back(keys[i]);
            run_load(ports[i], i == 2, 1'b0);
            check(n_abort == 1 && n_done == 0, "no single abort pulse");
            check(entry_out === `FLASH_ENTRY_DEFAULT, "abort entry wrong");
            check(entry_valid_out === 1'b1 && got.size() == 0, "abort state wrong");
        end
        $display("test rejected keys finished");
    endtask

    // ==================================================
    // main sequence
    initial begin
        nrst_in = 1'b0;
        start_in = 1'b0;
        port_in = boot_loader_pkg::PORT_SERIAL;
        repeat (3) @(posedge clk_in);
        #1 nrst_in = 1'b1;
        check(done_out === 1'b0 && mem_we_out === 1'b0 && busy_out === 1'b0, "reset outputs wrong");
        t_word_parallel();
        t_byte_parallel();
        t_byte_eeprom_empty();
        t_byte_serial();
        t_reject();
        stop_test();
    end
endmodule // tb_boot_stream_block_loader
